// ---- rtl/dmc_ctrl.sv ----
// How it works
// - Each read-modify-write column cycle lasts at least 230 ns.
// - Column strobe stays high at least 60 ns between pulses.
// - Column strobe low at least 75 ns, at most 10,000 ns.
// - Row strobe high at least 100 ns before the next row cycle.
// - Row strobe low at least 150 ns, at most 10,000 ns.
// - Row strobe falls at least 25 ns before column strobe falls.
// - Read-modify-write: write strobe at least 110 ns after column falls.
// - Read-modify-write: write strobe at least 185 ns after row falls.
// - Refresh: column strobe falls at least 30 ns before row strobe.
// - Output enable is off before write data drives the shared pins.
// - Data waits at least 30 ns after output enable rises.
// - Column low stretches until write delay and write set-up are met.
`include "dmc_defs.svh"
module dmc_ctrl (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             req_valid,
  input  wire dmc_pkg::dmc_req_t req,
  output logic                  req_ready,
  output logic                  rsp_valid,
  output logic [3:0]            rsp_rdata,
  input  wire logic [3:0]       shared_data_pins_in,
  output dmc_pkg::dmc_pins_t    pins
);
  typedef struct packed {
    dmc_pkg::dmc_state_t   st;
    dmc_pkg::dmc_req_t     cur;
    dmc_pkg::dmc_pins_t    pins;
    logic [`DMC_CNT_W-1:0] cnt;
    logic [`DMC_CNT_W-1:0] ras_cnt;
    logic                  ready;
    logic                  rsp;
    logic [3:0]            rdata;
    logic                  ref_ack;
  } dmc_st_t;

  dmc_st_t s_q;
  dmc_st_t s_d;
  logic    ref_due;

  dmc_ref_timer u_ref (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ack     (s_q.ref_ack),
    .due     (ref_due)
  );

  localparam logic [`DMC_CNT_W-1:0] N_CAS = `DMC_CNT_W'(`DMC_N_CAS);
  localparam logic [`DMC_CNT_W-1:0] N_RAS = `DMC_CNT_W'(`DMC_N_RAS);
  localparam logic [`DMC_CNT_W-1:0] N_RP = `DMC_CNT_W'(`DMC_N_RP);
  localparam logic [`DMC_CNT_W-1:0] N_CP = `DMC_CNT_W'(`DMC_N_CP);
  localparam logic [`DMC_CNT_W-1:0] N_RCD = `DMC_CNT_W'(`DMC_N_RCD);
  localparam logic [`DMC_CNT_W-1:0] N_CWD = `DMC_CNT_W'(`DMC_N_CWD);
  localparam logic [`DMC_CNT_W-1:0] N_RWD = `DMC_CNT_W'(`DMC_N_RWD);
  localparam logic [`DMC_CNT_W-1:0] N_CSR = `DMC_CNT_W'(`DMC_N_CSR);
  localparam logic [`DMC_CNT_W-1:0] N_GDD = `DMC_CNT_W'(`DMC_N_GDD);
  localparam logic [`DMC_CNT_W-1:0] N_CWL = `DMC_CNT_W'(`DMC_N_CWL);
  localparam logic [`DMC_CNT_W-1:0] N_PCM = `DMC_CNT_W'(`DMC_N_PCM);
  localparam logic [`DMC_CNT_W-1:0] ONE = `DMC_CNT_W'(1);
  localparam logic [`DMC_CNT_W-1:0] N_CAS_MAX = `DMC_CNT_W'(`DMC_N_CAS_MAX);

  always_comb begin
    s_d = s_q;
    s_d.rsp = 1'b0;
    s_d.ref_ack = 1'b0;
    s_d.cnt = s_q.cnt + ONE;
    if (!s_q.pins.ras_n) begin
      s_d.ras_cnt = s_q.ras_cnt + ONE;
    end
    unique case (s_q.st)
      dmc_pkg::DMC_IDLE: begin
        s_d.pins.dq_oe = 1'b0;
        s_d.pins.we_n = 1'b1;
        s_d.pins.oe_n = 1'b1;
        // Precharge time is counted from the row release
        if (s_q.cnt >= N_RP - ONE) begin
          // A request met by ready high is owed; refresh waits out that one access
          if (req_valid && s_q.ready) begin
            s_d.ready = 1'b0;
            s_d.cur = req;
            s_d.pins.addr = req.row;
            s_d.st = dmc_pkg::DMC_ROW;
          end else if (ref_due) begin
            s_d.ready = 1'b0;
            s_d.ref_ack = 1'b1;
            s_d.pins.cas_n = 1'b0;
            s_d.cnt = '0;
            s_d.st = dmc_pkg::DMC_REF_CAS;
          end else begin
            s_d.ready = 1'b1;
          end
        end
      end
      dmc_pkg::DMC_ROW: begin
        // Row address was set up one cycle ahead of the strobe
        s_d.pins.ras_n = 1'b0;
        s_d.ras_cnt = '0;
        s_d.cnt = '0;
        s_d.st = dmc_pkg::DMC_RCD;
      end
      dmc_pkg::DMC_RCD: begin
        s_d.pins.addr = s_q.cur.col;
        // Output enable stays high here for writes; idle already raised it ahead of data
        if (s_q.cur.op == dmc_pkg::DMC_OP_WRITE) begin
          s_d.pins.oe_n = 1'b1;
        end else begin
          s_d.pins.oe_n = 1'b0;
        end
        if (s_q.cnt >= N_RCD - ONE && s_q.cnt >= N_GDD - ONE) begin
          s_d.pins.cas_n = 1'b0;
          s_d.cnt = '0;
          if (s_q.cur.op == dmc_pkg::DMC_OP_WRITE) begin
            s_d.pins.we_n = 1'b0;
            s_d.pins.dq_out = s_q.cur.wdata;
            s_d.pins.dq_oe = 1'b1;
          end
          s_d.st = dmc_pkg::DMC_CASL;
        end
      end
      dmc_pkg::DMC_CASL: begin
        if (s_q.cur.op == dmc_pkg::DMC_OP_RMW) begin
          if (s_q.cnt >= N_CWD - ONE && s_q.ras_cnt >= N_RWD - ONE) begin
            s_d.rdata = shared_data_pins_in;
            s_d.pins.oe_n = 1'b1;
            s_d.st = dmc_pkg::DMC_WAIT_WE;
          end
        end else if (s_q.cnt >= N_CAS - ONE && s_q.ras_cnt >= N_RAS - ONE) begin
          s_d.rdata = shared_data_pins_in;
          s_d.rsp = (s_q.cur.op == dmc_pkg::DMC_OP_READ);
          s_d.pins.cas_n = 1'b1;
          s_d.pins.ras_n = 1'b1;
          s_d.cnt = '0;
          s_d.st = dmc_pkg::DMC_PRE;
        end
      end
      dmc_pkg::DMC_WAIT_WE: begin
        // One cycle of output-enable-high before write data
        s_d.pins.we_n = 1'b0;
        s_d.pins.dq_out = s_q.cur.wdata;
        s_d.pins.dq_oe = 1'b1;
        s_d.st = dmc_pkg::DMC_CASH;
        s_d.ras_cnt = s_q.ras_cnt + ONE;
      end
      dmc_pkg::DMC_CASH: begin
        // Column low is stretched until write set-up before release holds
        if (s_q.cnt >= N_PCM - N_CP - ONE && s_q.ras_cnt >= N_RAS - ONE
            && s_q.cnt >= N_CAS - ONE && s_q.cnt >= N_CWD + N_CWL - ONE) begin
          s_d.rsp = 1'b1;
          s_d.pins.cas_n = 1'b1;
          s_d.pins.ras_n = 1'b1;
          s_d.cnt = '0;
          s_d.st = dmc_pkg::DMC_PRE;
        end
      end
      dmc_pkg::DMC_PRE: begin
        // Column high also covers its own minimum; both counted together
        s_d.pins.dq_oe = 1'b0;
        s_d.pins.we_n = 1'b1;
        s_d.pins.oe_n = 1'b1;
        if (s_q.cnt >= N_CP - ONE) begin
          s_d.st = dmc_pkg::DMC_IDLE;
        end
      end
      dmc_pkg::DMC_REF_CAS: begin
        if (s_q.cnt >= N_CSR - ONE) begin
          s_d.pins.ras_n = 1'b0;
          s_d.ras_cnt = '0;
          s_d.cnt = '0;
          s_d.st = dmc_pkg::DMC_REF_RAS;
        end
      end
      dmc_pkg::DMC_REF_RAS: begin
        if (s_q.ras_cnt >= N_RAS - ONE && s_q.cnt >= N_CAS - ONE) begin
          s_d.pins.ras_n = 1'b1;
          s_d.pins.cas_n = 1'b1;
          s_d.cnt = '0;
          s_d.st = dmc_pkg::DMC_PRE;
        end
      end
      default: s_d.st = dmc_pkg::DMC_IDLE;
    endcase
    if (s_d.st == dmc_pkg::DMC_PRE && s_q.st != dmc_pkg::DMC_PRE) begin
      s_d.ready = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.pins.ras_n <= 1'b1;
      s_q.pins.cas_n <= 1'b1;
      s_q.pins.we_n <= 1'b1;
      s_q.pins.oe_n <= 1'b1;
      s_q.cnt <= `DMC_CNT_W'(`DMC_N_RP);
    end else begin
      s_q <= s_d;
    end
  end

  assign req_ready = s_q.ready;
  assign rsp_valid = s_q.rsp;
  assign rsp_rdata = s_q.rdata;
  assign pins = s_q.pins;

  // Helper counters for pulse widths
  logic [`DMC_CNT_W-1:0] cas_lo_q;
  logic [`DMC_CNT_W-1:0] cas_hi_q;
  logic [`DMC_CNT_W-1:0] ras_hi_q;
  logic [`DMC_CNT_W-1:0] we_ras_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cas_lo_q <= '0;
      cas_hi_q <= `DMC_CNT_W'(`DMC_N_CP);
      ras_hi_q <= `DMC_CNT_W'(`DMC_N_RP);
    end else begin
      cas_lo_q <= pins.cas_n ? '0 : cas_lo_q + ONE;
      cas_hi_q <= pins.cas_n ? ((&cas_hi_q) ? cas_hi_q : cas_hi_q + ONE) : '0;
      ras_hi_q <= pins.ras_n ? ((&ras_hi_q) ? ras_hi_q : ras_hi_q + ONE) : '0;
    end
  end
  assign we_ras_q = s_q.ras_cnt;

  property p_cas_low_min;
    @(posedge clk_sys) disable iff (!arst_n)
      $rose(pins.cas_n) |-> $past(cas_lo_q) >= N_CAS - ONE;
  endproperty
  a_cas_low_min: assert property (p_cas_low_min) else $error("column low too short");

  property p_cas_low_max;
    @(posedge clk_sys) disable iff (!arst_n)
      !pins.cas_n |-> cas_lo_q < N_CAS_MAX;
  endproperty
  a_cas_low_max: assert property (p_cas_low_max) else $error("column low too long");

  property p_cas_high_min;
    @(posedge clk_sys) disable iff (!arst_n)
      $fell(pins.cas_n) |-> $past(cas_hi_q) >= N_CP;
  endproperty
  a_cas_high_min: assert property (p_cas_high_min) else $error("column high too short");

  property p_ras_high_min;
    @(posedge clk_sys) disable iff (!arst_n)
      $fell(pins.ras_n) |-> $past(ras_hi_q) >= N_RP;
  endproperty
  a_ras_high_min: assert property (p_ras_high_min) else $error("row precharge too short");

  property p_ras_low_min;
    @(posedge clk_sys) disable iff (!arst_n)
      $rose(pins.ras_n) |-> $past(s_q.ras_cnt) >= N_RAS - ONE;
  endproperty
  a_ras_low_min: assert property (p_ras_low_min) else $error("row low too short");

  // An access column strobe must not fall on the edge that lowers the row strobe
  property p_rcd;
    @(posedge clk_sys) disable iff (!arst_n)
      $fell(pins.cas_n) && !pins.ras_n |-> !$past(pins.ras_n);
  endproperty
  a_rcd: assert property (p_rcd) else $error("column fell with row");

  property p_cbr;
    @(posedge clk_sys) disable iff (!arst_n)
      $fell(pins.ras_n) && !pins.cas_n |-> !$past(pins.cas_n);
  endproperty
  a_cbr: assert property (p_cbr) else $error("refresh column lead too short");

  property p_oe_before_data;
    @(posedge clk_sys) disable iff (!arst_n)
      $rose(pins.dq_oe) |-> $past(pins.oe_n) && pins.oe_n;
  endproperty
  a_oe_before_data: assert property (p_oe_before_data) else $error("data with output on");

  property p_rmw_we;
    @(posedge clk_sys) disable iff (!arst_n)
      $fell(pins.we_n) && s_q.cur.op == dmc_pkg::DMC_OP_RMW
        |-> $past(s_q.cnt) >= N_CWD && $past(we_ras_q) >= N_RWD;
  endproperty
  a_rmw_we: assert property (p_rmw_we) else $error("write strobe too early");

  property p_ras_max;
    @(posedge clk_sys) disable iff (!arst_n)
      !pins.ras_n |-> s_q.ras_cnt < `DMC_CNT_W'(100);
  endproperty
  a_ras_max: assert property (p_ras_max) else $error("row low too long");

  c_read: cover property (@(posedge clk_sys) disable iff (!arst_n)
    rsp_valid && s_q.cur.op == dmc_pkg::DMC_OP_READ);
  c_rmw: cover property (@(posedge clk_sys) disable iff (!arst_n)
    rsp_valid && s_q.cur.op == dmc_pkg::DMC_OP_RMW);
  c_ref: cover property (@(posedge clk_sys) disable iff (!arst_n)
    s_q.st == dmc_pkg::DMC_REF_RAS);
endmodule // dmc_ctrl

// ---- rtl/dmc_defs.svh ----
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH

`define DMC_CLK_NS 100
// Timing figures in ns, faster grade
`define DMC_T_PCM_NS 230
`define DMC_T_CP_NS 60
`define DMC_T_CAS_NS 75
`define DMC_T_CAS_MAX_NS 10000
`define DMC_T_RP_NS 100
`define DMC_T_RAS_NS 150
`define DMC_T_RAS_MAX_NS 10000
`define DMC_T_RCD_NS 25
`define DMC_T_CWD_NS 110
`define DMC_T_RWD_NS 185
`define DMC_T_CSR_NS 30
`define DMC_T_GDD_NS 30
`define DMC_T_CWL_NS 45
`define DMC_T_REF_NS 4000000
`define DMC_REF_ROWS 256
// Cycle counts: minimums round up, maximums round down
`define DMC_CYC_MIN(ns) (((ns) + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_CYC_MAX(ns) ((ns) / `DMC_CLK_NS)
`define DMC_N_PCM `DMC_CYC_MIN(`DMC_T_PCM_NS)
`define DMC_N_CP `DMC_CYC_MIN(`DMC_T_CP_NS)
`define DMC_N_CAS `DMC_CYC_MIN(`DMC_T_CAS_NS)
`define DMC_N_CAS_MAX `DMC_CYC_MAX(`DMC_T_CAS_MAX_NS)
`define DMC_N_RP `DMC_CYC_MIN(`DMC_T_RP_NS)
`define DMC_N_RAS `DMC_CYC_MIN(`DMC_T_RAS_NS)
`define DMC_N_RAS_MAX `DMC_CYC_MAX(`DMC_T_RAS_MAX_NS)
`define DMC_N_RCD `DMC_CYC_MIN(`DMC_T_RCD_NS)
`define DMC_N_CWD `DMC_CYC_MIN(`DMC_T_CWD_NS)
`define DMC_N_RWD `DMC_CYC_MIN(`DMC_T_RWD_NS)
`define DMC_N_CSR `DMC_CYC_MIN(`DMC_T_CSR_NS)
`define DMC_N_GDD `DMC_CYC_MIN(`DMC_T_GDD_NS)
`define DMC_N_CWL `DMC_CYC_MIN(`DMC_T_CWL_NS)
// Refresh spacing per row, rounded down
`define DMC_N_REF (`DMC_T_REF_NS / `DMC_REF_ROWS / `DMC_CLK_NS)
`define DMC_CNT_W 8
`define DMC_REF_W 10

`endif

// ---- rtl/dmc_pkg.sv ----
package dmc_pkg;
  typedef enum logic [1:0] {
    DMC_OP_READ,
    DMC_OP_WRITE,
    DMC_OP_RMW
  } dmc_op_t;

  typedef struct packed {
    dmc_op_t     op;
    logic [7:0]  row;
    logic [7:0]  col;
    logic [3:0]  wdata;
  } dmc_req_t;

  typedef struct packed {
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        oe_n;
    logic [7:0]  addr;
    logic [3:0]  dq_out;
    logic        dq_oe;
  } dmc_pins_t;

  typedef enum logic [3:0] {
    DMC_IDLE,
    DMC_ROW,
    DMC_RCD,
    DMC_CASL,
    DMC_WAIT_WE,
    DMC_CASH,
    DMC_PRE,
    DMC_REF_CAS,
    DMC_REF_RAS
  } dmc_state_t;
endpackage

// ---- rtl/dmc_ref_timer.sv ----
`include "dmc_defs.svh"
module dmc_ref_timer (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic ack,
  output logic      due
);
  typedef struct packed {
    logic [`DMC_REF_W-1:0] cnt;
    logic                  due;
  } dmc_rt_t;
  dmc_rt_t s_q;
  dmc_rt_t s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.cnt == `DMC_REF_W'(`DMC_N_REF - 1)) begin
      s_d.cnt = '0;
      s_d.due = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + `DMC_REF_W'(1);
    end
    // A new tick wins over the acknowledge
    if (ack && !(s_q.cnt == `DMC_REF_W'(`DMC_N_REF - 1))) begin
      s_d.due = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign due = s_q.due;
endmodule // dmc_ref_timer

// ---- sim/dmc_mem_model.sv ----
module dmc_mem_model (
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic       oe_n,
  input  wire logic [7:0] addr,
  input  wire logic [3:0] dq_in,
  output logic [3:0]      dq_drv,
  output logic            dq_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mem [0:65535];
  logic [7:0] row_q;
  logic [7:0] col_q;
  logic [3:0] last_q = 4'h0;
  // Column strobe falling with row high is a refresh: no address is taken
  always @(negedge ras_n) if (cas_n) row_q = addr;
  // Small delay lets address, write strobe and data from the same edge settle
  always @(negedge cas_n) if (!ras_n) begin
    #1 col_q = addr;
    if (!we_n) mem[{row_q, col_q}] = dq_in;
  end
  always @(negedge we_n) if (!ras_n && !cas_n) begin
    #1 mem[{row_q, col_q}] = dq_in;
  end
  assign dq_en = !ras_n && !cas_n && !oe_n && we_n;
  // Released pins show the inverse of the last word, never a stale copy
  assign dq_drv = dq_en ? mem[{row_q, col_q}] : ~last_q;
  always @(negedge dq_en) last_q = mem[{row_q, col_q}];
endmodule // dmc_mem_model

// ---- sim/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_sys = 1'b0;
  logic               arst_n = 1'b0;
  logic               req_valid = 1'b0;
  dmc_pkg::dmc_req_t  req = '0;
  logic               req_ready;
  logic               rsp_valid;
  logic [3:0]         rsp_rdata;
  logic [3:0]         mem_dq;
  logic               mem_en;
  logic [3:0]         dq_w;
  dmc_pkg::dmc_pins_t pins;
  int                 bad_count = 0;
  int                 checks_done = 0;
  int                 cyc = 0;
  int                 seed = 99838;
  int                 n_cbr = 0;
  realtime            t_rf = -1e9, t_rr = -1e9, t_cf = -1e9, t_cr = -1e9;
  realtime            t_wf = -1e9, t_or = -1e9, t_cbr = -1e9;
  logic               rmw_cur = 1'b0;
  logic               rmw_prev = 1'b0;
  logic [7:0]         cur_row;
  logic [7:0]         cur_col;
  logic [15:0]        pool [8];
  logic [3:0]         shadow [8];

  always #50 clk_sys = ~clk_sys;
  assign dq_w = pins.dq_oe ? pins.dq_out : mem_dq;

  dmc_ctrl dmc_ctrl_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .shared_data_pins_in(dq_w), .pins(pins)
  );
  dmc_mem_model dmc_mem_model_i (
    .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n), .oe_n(pins.oe_n),
    .addr(pins.addr), .dq_in(dq_w), .dq_drv(mem_dq), .dq_en(mem_en)
  );

  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      bad_count++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("ERROR at %0t: timeout", $time);
      give_verdict();
    end
    if (arst_n && pins.dq_oe === 1'b1 && mem_en === 1'b1) chk(0, "bus clash");
  end

  always @(negedge pins.ras_n) if (arst_n) begin
    chk($realtime - t_rr >= 100, "row high short");
    if (pins.cas_n === 1'b0) begin
      chk($realtime - t_cf >= 30, "refresh column lead short");
      // A refresh tick may have to wait out one access
      if (n_cbr > 0) chk($realtime - t_cbr <= 17000, "refresh late");
      n_cbr++;
      t_cbr = $realtime;
    end else chk(pins.addr === cur_row, "row address");
    t_rf = $realtime;
  end

  always @(posedge pins.ras_n) if (arst_n) begin
    chk($realtime - t_rf >= 150 && $realtime - t_rf <= 10000, "row low width");
    t_rr = $realtime;
  end

  always @(negedge pins.cas_n) if (arst_n) begin
    chk($realtime - t_cr >= 60, "column high short");
    if (rmw_prev) chk($realtime - t_cf >= 230, "rmw column cycle short");
    rmw_prev = 1'b0;
    if (pins.ras_n === 1'b0) begin
      chk($realtime - t_rf >= 25, "row to column short");
      chk(pins.addr === cur_col, "column address");
      rmw_prev = rmw_cur;
    end
    t_cf = $realtime;
  end

  always @(posedge pins.cas_n) if (arst_n) begin
    chk($realtime - t_cf >= 75 && $realtime - t_cf <= 10000, "column low width");
    if (rmw_cur) chk($realtime - t_wf >= 45, "write set-up short");
    t_cr = $realtime;
  end

  always @(negedge pins.we_n) if (arst_n && rmw_cur) begin
    chk($realtime - t_cf >= 110, "column to write short");
    chk($realtime - t_rf >= 185, "row to write short");
    t_wf = $realtime;
  end

  always @(posedge pins.oe_n) t_or = $realtime;
  always @(posedge pins.dq_oe) if (arst_n) begin
    chk(pins.oe_n === 1'b1, "data with output on");
    chk($realtime - t_or >= 30, "output off to data short");
  end

  task automatic do_op(input dmc_pkg::dmc_op_t op, input int k, input logic [3:0] wd);
    int n;
    n = 0;
    @(negedge clk_sys);
    req.op = op;
    req.row = pool[k][15:8];
    req.col = pool[k][7:0];
    req.wdata = wd;
    cur_row = pool[k][15:8];
    cur_col = pool[k][7:0];
    rmw_cur = (op == dmc_pkg::DMC_OP_RMW);
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    if (op != dmc_pkg::DMC_OP_WRITE) begin
      while (rsp_valid !== 1'b1 && n < 80) begin
        @(negedge clk_sys);
        n++;
      end
      chk(rsp_valid === 1'b1 && rsp_rdata === shadow[k], "read data");
    end
    if (op != dmc_pkg::DMC_OP_READ) shadow[k] = wd;
    repeat (2) @(negedge clk_sys);
    rmw_cur = 1'b0;
  endtask

  initial begin
    int k;
    logic [3:0] d;
    dmc_pkg::dmc_op_t op;
    for (k = 0; k < 8; k++) pool[k] = 16'($random(seed));
    pool[0] = 16'h00FF;
    pool[1] = 16'hFF00;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) arst_n = 1'b1;
    for (k = 0; k < 8; k++) do_op(dmc_pkg::DMC_OP_WRITE, k, 4'(k * 3 + 1));
    for (k = 0; k < 8; k++) do_op(dmc_pkg::DMC_OP_READ, k, 4'h0);
    repeat (60) begin
      k = int'($unsigned($random(seed)) % 8);
      op = dmc_pkg::dmc_op_t'($unsigned($random(seed)) % 3);
      d = 4'($random(seed));
      do_op(op, k, d);
    end
    // Back-to-back read-modify-writes flipping every bit of one word
    do_op(dmc_pkg::DMC_OP_RMW, 2, 4'hF);
    do_op(dmc_pkg::DMC_OP_RMW, 2, 4'h0);
    do_op(dmc_pkg::DMC_OP_READ, 2, 4'h0);
    repeat (800) @(negedge clk_sys);
    chk(n_cbr >= int'($realtime / 15625.0) - 2, "too few refreshes");
    do_op(dmc_pkg::DMC_OP_READ, 0, 4'h0);
    give_verdict();
  end
endmodule // tb_top
